// File: rsr_bank_props.sv
// concurrent checks on the register bank ports
`timescale 1ns/1ps
`include "rsr_params.svh"
module rsr_bank_props #(
	parameter logic [7:0] PART_ID = `RSR_PART_ID_DEFAULT, // arbitrary value
	parameter logic [7:0] REV_ID  = `RSR_REV_ID_DEFAULT   // arbitrary value
) (
	input wire logic       clk,
	input wire logic       rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_write,
	input wire logic       reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic       reg_rvalid,
	input wire logic       demodulator_order_sel,
	input wire logic       temp_sensor_buffer_en,
	input wire logic       switching_regulator_off,
	input wire logic       active_antenna,
	input wire logic       transmit_queue_full,
	input wire logic       receive_queue_empty,
	input wire logic       low_frequency_oscillator_error,
	input wire logic [6:0] main_controller_state,
	input wire logic       crystal_running,
	input wire logic [6:0] transmit_queue_count
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_read_answer;
		reg_read |=> reg_rvalid;
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("read got no answer");
	property p_read_quiet;
		!reg_read |=> !reg_rvalid;
	endproperty
	a_read_quiet: assert property (p_read_quiet) else $error("answer without read");
	property p_order_write;
		reg_write && reg_addr == `RSR_ADDR_DEMOD_CONFIG |=>
			demodulator_order_sel == $past(reg_wdata[`RSR_DEMOD_ORDER_BIT]);
	endproperty
	a_order_write: assert property (p_order_write) else $error("order bit not written");
	property p_power_write;
		reg_write && reg_addr == `RSR_ADDR_POWER_CONFIG |=>
			{temp_sensor_buffer_en, switching_regulator_off} == $past(reg_wdata[6:5]);
	endproperty
	a_power_write: assert property (p_power_write) else $error("power bits not written");
	property p_power_hold;
		!(reg_write && reg_addr == `RSR_ADDR_POWER_CONFIG) |=>
			$stable({temp_sensor_buffer_en, switching_regulator_off});
	endproperty
	a_power_hold: assert property (p_power_hold) else $error("power bits moved");
	property p_part_id;
		reg_read && reg_addr == `RSR_ADDR_PART_ID |=> reg_rdata == PART_ID;
	endproperty
	a_part_id: assert property (p_part_id) else $error("part code wrong");
	property p_state_hi;
		reg_read && reg_addr == `RSR_ADDR_CTRL_HI |=> reg_rdata == {4'h5, $past(active_antenna),
			$past(transmit_queue_full), $past(receive_queue_empty),
			$past(low_frequency_oscillator_error)};
	endproperty
	a_state_hi: assert property (p_state_hi) else $error("upper state byte wrong");
	property p_state_lo;
		reg_read && reg_addr == `RSR_ADDR_CTRL_LO |=>
			reg_rdata == {$past(main_controller_state), $past(crystal_running)};
	endproperty
	a_state_lo: assert property (p_state_lo) else $error("lower state byte wrong");
	property p_txq_level;
		reg_read && reg_addr == `RSR_ADDR_TXQ_LEVEL |=>
			reg_rdata == {1'b0, $past(transmit_queue_count)};
	endproperty
	a_txq_level: assert property (p_txq_level) else $error("queue level wrong");
endmodule

bind rsr_register_bank rsr_bank_props #(.PART_ID(PART_ID), .REV_ID(REV_ID)) u_props (
	.clk, .rst_b, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .reg_rvalid,
	.demodulator_order_sel, .temp_sensor_buffer_en, .switching_regulator_off,
	.active_antenna, .transmit_queue_full, .receive_queue_empty,
	.low_frequency_oscillator_error, .main_controller_state, .crystal_running,
	.transmit_queue_count);

// File: rsr_capture.sv
// word that holds its value until a load strobe takes a new one
`timescale 1ns/1ps

module rsr_capture #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] data_in,
	output logic      [WIDTH-1:0] data_out
);
	typedef struct packed {
		logic [WIDTH-1:0] word;
	} rsr_capture_state_type;

	rsr_capture_state_type state_reg;
	rsr_capture_state_type state_next;

	always_comb begin
		state_next = state_reg;
		if (load) begin
			state_next.word = data_in;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign data_out = state_reg.word;
endmodule

// File: rsr_event_byte.sv
// one byte of sticky event flags, cleared by reading it
`timescale 1ns/1ps

module rsr_event_byte
	import rsr_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic [7:0] event_set,
	input  wire logic       read_clear,
	output logic      [7:0] flags
);
	rsr_event_state_type state_reg;
	rsr_event_state_type state_next;

	always_comb begin
		state_next = state_reg;
		// set is ORed in after the clear so an event landing on the read stays pending
		if (read_clear) begin
			state_next.flags = 8'h00; // [RQ19]
		end
		state_next.flags = state_next.flags | event_set; // [RQ19]
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign flags = state_reg.flags;
endmodule

// File: rsr_host_model.sv
// host side model driving the register port
`timescale 1ns/1ps
module rsr_host_model (
	input  wire logic       clk,
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wdata,
	output logic            reg_write,
	output logic            reg_read,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       reg_rvalid
);
	initial begin
		{reg_addr, reg_wdata, reg_write, reg_read} = '0;
	end
	// released address and data flip so stale values never look valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		{reg_addr, reg_wdata, reg_write} = {a, d, 1'b1};
		@(posedge clk);
		#1;
		{reg_addr, reg_wdata, reg_write} = {~a, ~d, 1'b0};
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(posedge clk);
		#1;
		{reg_addr, reg_read} = {a, 1'b1};
		@(posedge clk);
		#1;
		{reg_addr, reg_read} = {~a, 1'b0};
		{d, v} = {reg_rdata, reg_rvalid};
	endtask
	// order bit cleared, reserved bits rewritten with their reset pattern
	task automatic init_radio;
		wr(8'hA3, 8'h35);
	endtask
endmodule

// File: rsr_params.svh
// offsets, field positions, reset values and identity defaults of the status register bank
`ifndef RSR_PARAMS_SVH
`define RSR_PARAMS_SVH

`define RSR_ADDR_MASK_B3       8'h90
`define RSR_ADDR_MASK_B2       8'h91
`define RSR_ADDR_MASK_B1       8'h92
`define RSR_ADDR_MASK_B0       8'h93
`define RSR_ADDR_DEMOD_CONFIG  8'hA3
`define RSR_ADDR_POWER_CONFIG  8'hA4
`define RSR_ADDR_CTRL_HI       8'hC0
`define RSR_ADDR_CTRL_LO       8'hC1
`define RSR_ADDR_TX_INFO       8'hC2
`define RSR_ADDR_RX_INFO       8'hC3
`define RSR_ADDR_FREQ_CORR     8'hC4
`define RSR_ADDR_LINK_B2       8'hC5
`define RSR_ADDR_LINK_B1       8'hC6
`define RSR_ADDR_LINK_B0       8'hC7
`define RSR_ADDR_SIG_STRENGTH  8'hC8
`define RSR_ADDR_LEN_HI        8'hC9
`define RSR_ADDR_LEN_LO        8'hCA
`define RSR_ADDR_CRC_B2        8'hCB
`define RSR_ADDR_CRC_B1        8'hCC
`define RSR_ADDR_CRC_B0        8'hCD
`define RSR_ADDR_CTRL_FIELD_0  8'hCE
`define RSR_ADDR_CTRL_FIELD_1  8'hCF
`define RSR_ADDR_CTRL_FIELD_2  8'hD0
`define RSR_ADDR_CTRL_FIELD_3  8'hD1
`define RSR_ADDR_SRC_ADDR      8'hD2
`define RSR_ADDR_DST_ADDR      8'hD3
`define RSR_ADDR_CIPHER_FIRST  8'hD4
`define RSR_ADDR_CIPHER_LAST   8'hE3
`define RSR_ADDR_CAL_HI        8'hE4
`define RSR_ADDR_CAL_LO        8'hE5
`define RSR_ADDR_TXQ_LEVEL     8'hE6
`define RSR_ADDR_RXQ_LEVEL     8'hE7
`define RSR_ADDR_PART_ID       8'hF0
`define RSR_ADDR_REV_ID        8'hF1
`define RSR_ADDR_EVENTS_B3     8'hFA
`define RSR_ADDR_EVENTS_B2     8'hFB
`define RSR_ADDR_EVENTS_B1     8'hFC
`define RSR_ADDR_EVENTS_B0     8'hFD

`define RSR_DEMOD_ORDER_BIT    1
`define RSR_DEM_RSVD_HI        6'h0D
`define RSR_DEM_RSVD_LO        1'h1
`define RSR_DEMOD_ORDER_RESET  1'h1
`define RSR_TS_BUFFER_BIT      6
`define RSR_SMPS_OFF_BIT       5
`define RSR_CTRL_HI_RSVD       4'h5
`define RSR_MASK_RESET         32'h0000_0000
`define RSR_PART_ID_DEFAULT    8'hA5
`define RSR_REV_ID_DEFAULT     8'h5A
`define RSR_RECORD_WIDTH       127

`endif

// File: rsr_pkg.sv
// types shared by the status register bank modules
package rsr_pkg;

	typedef struct packed {
		logic [31:0] mask;
		logic        demod_order;
		logic        ts_buffer;
		logic        smps_off;
		logic [3:0]  tx_count;
		logic [7:0]  rdata;
		logic        rvalid;
		logic        route;
	} rsr_bank_state_type;

	typedef struct packed {
		logic [7:0] flags;
	} rsr_event_state_type;

endpackage

// File: rsr_register_bank.sv
// byte-wide configuration and status register bank of the transceiver
// How it works
// RQ1: 32-bit routing mask in four bytes, msb first; masked events drive gpio.
// RQ2: host clears demodulator order bit, reset one, during radio initialisation.
// RQ3: host keeps reserved demodulator config bits at reset pattern when writing.
// RQ4: temperature buffer enable bit one buffers the sensor output; zero leaves unbuffered.
// RQ5: regulator-off bit zero keeps switching regulator on; one turns it off.
// RQ6: upper state byte: antenna bit3, tx full bit2, rx empty bit1, cal error bit0.
// RQ7: lower state byte: controller state in bits 7:1, crystal running in bit0.
// RQ8: tx info: sequence number and count; count updates only at limit or ack.
// RQ9: rx info: negative-ack flag in bit2, sequence number in bits 1:0.
// RQ10: per packet latch correction, preamble, carrier+sync, gain and strength bytes.
// RQ11: received length over two bytes, high byte times 256 plus low.
// RQ12: checksum in three bytes, byte 2 lowest address, byte 0 highest.
// RQ13: four control bytes, byte 0 at lowest address up to byte 3.
// RQ14: source address byte first, destination address byte second.
// RQ15: 128-bit cipher result as sixteen bytes, most significant byte lowest address.
// RQ16: oscillator trim and feedback words across byte boundary, seven-bit synth word.
// RQ17: transmit and receive queue fill levels, seven bits each, zero to 96.
// RQ18: 32 event flags in four bytes, msb first, matching the mask bits.
// RQ19: reading an event byte clears it; same-cycle events stay pending.
// RQ20: writes to read-only status and identity registers are ignored.
`timescale 1ns/1ps
`include "rsr_params.svh"

module rsr_register_bank #(
	parameter logic [7:0] PART_ID = `RSR_PART_ID_DEFAULT, // arbitrary value
	parameter logic [7:0] REV_ID  = `RSR_REV_ID_DEFAULT   // arbitrary value
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	// register port behind the serial configuration interface
	input  wire logic [7:0]   reg_addr,
	input  wire logic [7:0]   reg_wdata,
	input  wire logic         reg_write,
	input  wire logic         reg_read,
	output logic      [7:0]   reg_rdata,
	output logic              reg_rvalid,
	// configuration outputs and the routed interrupt pin
	output logic              demodulator_order_sel,
	output logic              temp_sensor_buffer_en,
	output logic              switching_regulator_off,
	output logic              irq_route_out,
	// live status
	input  wire logic         active_antenna,
	input  wire logic         transmit_queue_full,
	input  wire logic         receive_queue_empty,
	input  wire logic         low_frequency_oscillator_error,
	input  wire logic [6:0]   main_controller_state,
	input  wire logic         crystal_running,
	input  wire logic [1:0]   transmit_sequence_number,
	input  wire logic [3:0]   transmission_count,
	input  wire logic         transmission_count_update,
	input  wire logic [6:0]   transmit_queue_count,
	input  wire logic [6:0]   receive_queue_count,
	// per-packet record
	input  wire logic         packet_done,
	input  wire logic         received_negative_ack,
	input  wire logic [1:0]   received_sequence_number,
	input  wire logic [7:0]   frequency_correction_word,
	input  wire logic [7:0]   preamble_quality,
	input  wire logic         carrier_sense,
	input  wire logic [6:0]   sync_quality,
	input  wire logic [3:0]   gain_word,
	input  wire logic [7:0]   signal_strength_level,
	input  wire logic [15:0]  received_length,
	input  wire logic [23:0]  received_checksum,
	input  wire logic [31:0]  received_control,
	input  wire logic [7:0]   received_source,
	input  wire logic [7:0]   received_dest,
	// cipher and calibrators
	input  wire logic         cipher_done,
	input  wire logic [127:0] cipher_result,
	input  wire logic         calibration_done,
	input  wire logic [3:0]   oscillator_resistor_trim,
	input  wire logic [4:0]   oscillator_feedback_trim,
	input  wire logic [6:0]   synth_cal_word,
	// interrupt events, one-cycle pulses
	input  wire logic [31:0]  event_pulse
);
	import rsr_pkg::*;

	rsr_bank_state_type state_reg;
	rsr_bank_state_type state_next;

	logic [`RSR_RECORD_WIDTH-1:0] record_in;
	logic [`RSR_RECORD_WIDTH-1:0] record;
	logic [15:0]                  cal_word;
	logic [31:0]                  events;
	logic [3:0]                   event_read;
	logic [7:0]                   cipher_index;
	logic [7:0]                   read_value;

	// record fields packed in one word so a single strobe latches them together
	assign record_in = {received_negative_ack, received_sequence_number,
		frequency_correction_word, preamble_quality, carrier_sense, sync_quality,
		gain_word, signal_strength_level, received_length, received_checksum,
		received_control, received_source, received_dest};

	rsr_capture #(
		.WIDTH(`RSR_RECORD_WIDTH)
	) u_record (
		.clk     (clk),
		.rst_b   (rst_b),
		.load    (packet_done), // [RQ10]
		.data_in (record_in),
		.data_out(record)
	);

	logic [127:0] cipher_word;

	rsr_capture #(
		.WIDTH(128)
	) u_cipher (
		.clk     (clk),
		.rst_b   (rst_b),
		.load    (cipher_done), // [RQ15]
		.data_in (cipher_result),
		.data_out(cipher_word)
	);

	// trim word straddles the byte boundary: top 4 feedback bits low in the high byte
	rsr_capture #(
		.WIDTH(16)
	) u_cal (
		.clk     (clk),
		.rst_b   (rst_b),
		.load    (calibration_done),
		.data_in ({oscillator_resistor_trim, oscillator_feedback_trim,
			synth_cal_word}), // [RQ16]
		.data_out(cal_word)
	);

	// event byte k sits at the status offset 3-k, msb byte first
	always_comb begin
		event_read[3] = reg_read && (reg_addr == `RSR_ADDR_EVENTS_B3);
		event_read[2] = reg_read && (reg_addr == `RSR_ADDR_EVENTS_B2);
		event_read[1] = reg_read && (reg_addr == `RSR_ADDR_EVENTS_B1);
		event_read[0] = reg_read && (reg_addr == `RSR_ADDR_EVENTS_B0);
	end

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_events
			rsr_event_byte u_event (
				.clk       (clk),
				.rst_b     (rst_b),
				.event_set (event_pulse[8*g+7:8*g]),
				.read_clear(event_read[g]), // [RQ19]
				.flags     (events[8*g+7:8*g])
			);
		end
	endgenerate

	assign cipher_index = reg_addr - `RSR_ADDR_CIPHER_FIRST;

	always_comb begin
		read_value = 8'h00;
		unique case (reg_addr)
			`RSR_ADDR_MASK_B3:      read_value = state_reg.mask[31:24]; // [RQ1]
			`RSR_ADDR_MASK_B2:      read_value = state_reg.mask[23:16];
			`RSR_ADDR_MASK_B1:      read_value = state_reg.mask[15:8];
			`RSR_ADDR_MASK_B0:      read_value = state_reg.mask[7:0];
			`RSR_ADDR_DEMOD_CONFIG: read_value = {`RSR_DEM_RSVD_HI, state_reg.demod_order,
				`RSR_DEM_RSVD_LO};
			`RSR_ADDR_POWER_CONFIG: read_value = {1'b0, state_reg.ts_buffer,
				state_reg.smps_off, 5'h00};
			`RSR_ADDR_CTRL_HI:      read_value = {`RSR_CTRL_HI_RSVD, active_antenna,
				transmit_queue_full, receive_queue_empty,
				low_frequency_oscillator_error}; // [RQ6]
			`RSR_ADDR_CTRL_LO:      read_value = {main_controller_state,
				crystal_running}; // [RQ7]
			`RSR_ADDR_TX_INFO:      read_value = {2'b00, transmit_sequence_number,
				state_reg.tx_count}; // [RQ8]
			`RSR_ADDR_RX_INFO:      read_value = {5'h00, record[126:124]}; // [RQ9]
			`RSR_ADDR_FREQ_CORR:    read_value = record[123:116]; // [RQ10]
			`RSR_ADDR_LINK_B2:      read_value = record[115:108];
			`RSR_ADDR_LINK_B1:      read_value = record[107:100];
			`RSR_ADDR_LINK_B0:      read_value = {4'h0, record[99:96]};
			`RSR_ADDR_SIG_STRENGTH: read_value = record[95:88];
			`RSR_ADDR_LEN_HI:       read_value = record[87:80]; // [RQ11]
			`RSR_ADDR_LEN_LO:       read_value = record[79:72];
			`RSR_ADDR_CRC_B2:       read_value = record[71:64]; // [RQ12]
			`RSR_ADDR_CRC_B1:       read_value = record[63:56];
			`RSR_ADDR_CRC_B0:       read_value = record[55:48];
			`RSR_ADDR_CTRL_FIELD_0: read_value = record[23:16]; // [RQ13]
			`RSR_ADDR_CTRL_FIELD_1: read_value = record[31:24];
			`RSR_ADDR_CTRL_FIELD_2: read_value = record[39:32];
			`RSR_ADDR_CTRL_FIELD_3: read_value = record[47:40];
			`RSR_ADDR_SRC_ADDR:     read_value = record[15:8]; // [RQ14]
			`RSR_ADDR_DST_ADDR:     read_value = record[7:0];
			`RSR_ADDR_CAL_HI:       read_value = cal_word[15:8]; // [RQ16]
			`RSR_ADDR_CAL_LO:       read_value = cal_word[7:0];
			`RSR_ADDR_TXQ_LEVEL:    read_value = {1'b0, transmit_queue_count}; // [RQ17]
			`RSR_ADDR_RXQ_LEVEL:    read_value = {1'b0, receive_queue_count};
			`RSR_ADDR_PART_ID:      read_value = PART_ID;
			`RSR_ADDR_REV_ID:       read_value = REV_ID;
			`RSR_ADDR_EVENTS_B3:    read_value = events[31:24]; // [RQ18]
			`RSR_ADDR_EVENTS_B2:    read_value = events[23:16];
			`RSR_ADDR_EVENTS_B1:    read_value = events[15:8];
			`RSR_ADDR_EVENTS_B0:    read_value = events[7:0];
			default: begin
				// cipher bytes run msb first; other holes read zero
				if (reg_addr >= `RSR_ADDR_CIPHER_FIRST && reg_addr <= `RSR_ADDR_CIPHER_LAST) begin
					read_value = cipher_word[8'd127 - {cipher_index[4:0], 3'b000} -: 8]; // [RQ15]
				end
			end
		endcase
	end

	always_comb begin
		state_next = state_reg;
		state_next.rvalid = reg_read;
		if (reg_read) begin
			state_next.rdata = read_value;
		end
		// only the writable bytes decode; every other write falls through untouched
		if (reg_write) begin
			unique case (reg_addr)
				`RSR_ADDR_MASK_B3:      state_next.mask[31:24] = reg_wdata; // [RQ1]
				`RSR_ADDR_MASK_B2:      state_next.mask[23:16] = reg_wdata;
				`RSR_ADDR_MASK_B1:      state_next.mask[15:8] = reg_wdata;
				`RSR_ADDR_MASK_B0:      state_next.mask[7:0] = reg_wdata;
				// reserved bits are not stored, so a careless write cannot upset them
				`RSR_ADDR_DEMOD_CONFIG: state_next.demod_order = reg_wdata[`RSR_DEMOD_ORDER_BIT]; // [RQ3]
				`RSR_ADDR_POWER_CONFIG: begin
					state_next.ts_buffer = reg_wdata[`RSR_TS_BUFFER_BIT]; // [RQ4]
					state_next.smps_off  = reg_wdata[`RSR_SMPS_OFF_BIT]; // [RQ5]
				end
				default: state_next.mask = state_next.mask; // [RQ20]
			endcase
		end
		if (transmission_count_update) begin
			state_next.tx_count = transmission_count; // [RQ8]
		end
		// one cycle behind the flags, traded for a glitch-free registered pin
		state_next.route = |(events & state_reg.mask); // [RQ1]
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_reg             <= '0;
			state_reg.mask        <= `RSR_MASK_RESET;
			state_reg.demod_order <= `RSR_DEMOD_ORDER_RESET; // [RQ2]
		end else begin
			state_reg <= state_next;
		end
	end

	assign reg_rdata               = state_reg.rdata;
	assign reg_rvalid              = state_reg.rvalid;
	assign demodulator_order_sel   = state_reg.demod_order;
	assign temp_sensor_buffer_en   = state_reg.ts_buffer;
	assign switching_regulator_off = state_reg.smps_off;
	assign irq_route_out           = state_reg.route;
endmodule

// File: rsr_register_bank_tb_top.sv
// self-checking bench for the status register bank
`timescale 1ns/1ps
`include "rsr_params.svh"
module rsr_register_bank_tb_top;
	logic         clk = 1'b0;
	logic         rst_b = 1'b0;
	logic [7:0]   reg_addr, reg_wdata, reg_rdata, d;
	logic         reg_write, reg_read, reg_rvalid, dem, tsb, smps, irq, v;
	logic         ant = 1'b0, txf = 1'b0, rxe = 1'b0, lfe = 1'b0, crys = 1'b0, upd = 1'b0;
	logic         pkt = 1'b0, nack = 1'b0, cs = 1'b0, cip = 1'b0, cal = 1'b0;
	logic [1:0]   tsn = '0, rsn = '0;
	logic [3:0]   cnt = '0, gain = '0, rwt = '0;
	logic [4:0]   rfb = '0;
	logic [6:0]   mcs = '0, txq = '0, rxq = '0, sq = '0, syn = '0;
	logic [7:0]   afc = '0, pq = '0, rssi = '0, src = '0, dst = '0;
	logic [15:0]  len = '0;
	logic [23:0]  crc = '0;
	logic [31:0]  ctl = '0, ev = '0;
	logic [127:0] aes = '0;
	int           num_errors = 0;
	int           num_checks = 0;
	always #25 clk = ~clk;
	rsr_host_model u_host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
	rsr_register_bank u_dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .demodulator_order_sel(dem), .temp_sensor_buffer_en(tsb),
		.switching_regulator_off(smps), .irq_route_out(irq), .active_antenna(ant),
		.transmit_queue_full(txf), .receive_queue_empty(rxe), .low_frequency_oscillator_error(lfe),
		.main_controller_state(mcs), .crystal_running(crys), .transmit_sequence_number(tsn),
		.transmission_count(cnt), .transmission_count_update(upd), .transmit_queue_count(txq),
		.receive_queue_count(rxq), .packet_done(pkt), .received_negative_ack(nack),
		.received_sequence_number(rsn), .frequency_correction_word(afc), .preamble_quality(pq),
		.carrier_sense(cs), .sync_quality(sq), .gain_word(gain), .signal_strength_level(rssi),
		.received_length(len), .received_checksum(crc), .received_control(ctl),
		.received_source(src), .received_dest(dst), .cipher_done(cip), .cipher_result(aes),
		.calibration_done(cal), .oscillator_resistor_trim(rwt), .oscillator_feedback_trim(rfb),
		.synth_cal_word(syn), .event_pulse(ev));
	task automatic tick;
		@(posedge clk);
		#1;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] dd;
		logic       vv;
		u_host.rd(a, dd, vv);
		check("rvalid", vv, 1'b1);
		check($sformatf("reg %h", a), dd, exp);
	endtask
	task automatic t_reset;
		check("order", dem, 1'b1);
		check("buffer", {tsb, smps}, 2'h0);
		rd_chk(8'hA3, 8'h37);
		for (int k = 0; k < 4; k++) rd_chk(8'h90 + k[7:0], 8'h00);
		u_host.wr(8'hF0, 8'hFF);
		u_host.wr(8'hC4, 8'hFF);
		rd_chk(8'hF0, `RSR_PART_ID_DEFAULT);
		rd_chk(8'hF1, `RSR_REV_ID_DEFAULT);
		rd_chk(8'hC4, 8'h00);
		rd_chk(8'h50, 8'h00);
	endtask
	task automatic t_config;
		u_host.init_radio;
		check("order", dem, 1'b0);
		rd_chk(8'hA3, 8'h35);
		u_host.wr(8'hA4, 8'h60);
		check("buffer", {tsb, smps}, 2'h3);
		u_host.wr(8'hA4, 8'h40);
		check("buffer", {tsb, smps}, 2'h2);
		rd_chk(8'hA4, 8'h40);
	endtask
	task automatic t_status;
		{ant, txf, rxe, lfe, mcs, crys} = {4'hA, 7'h5B, 1'b1};
		{tsn, cnt, txq, rxq} = {2'h2, 4'h9, 7'h60, 7'h01};
		rd_chk(8'hC0, 8'h5A);
		rd_chk(8'hC1, 8'hB7);
		rd_chk(8'hC2, 8'h20);
		upd = 1'b1;
		tick;
		{upd, cnt} = {1'b0, 4'h3};
		rd_chk(8'hC2, 8'h29);
		rd_chk(8'hE6, 8'h60);
		rd_chk(8'hE7, 8'h01);
	endtask
	task automatic t_latched;
		logic [135:0] rec;
		logic [127:0] key;
		{nack, rsn, afc, pq, cs, sq, gain, rssi} = {3'h7, 16'h9C21, 1'b1, 7'h44, 4'hB, 8'hC7};
		{len, crc, ctl, src, dst} = {16'h0123, 24'hABCDEF, 32'h44332211, 16'h5EE5};
		rec = {5'h0, nack, rsn, afc, pq, cs, sq, 4'h0, gain, rssi, len, crc,
			ctl[7:0], ctl[15:8], ctl[23:16], ctl[31:24], src, dst};
		key = 128'h00112233445566778899AABBCCDDEEFF;
		{aes, rwt, rfb, syn} = {key, 4'hA, 5'h13, 7'h55};
		{pkt, cip, cal} = 3'h7;
		tick;
		{pkt, cip, cal} = 3'h0;
		{nack, rsn, afc, pq, cs, sq, gain, rssi, len, crc, ctl, src, dst} = '1;
		{aes, rwt, rfb, syn} = '0;
		// new inputs without a strobe must not reach the latched bytes
		for (int k = 0; k < 17; k++) rd_chk(8'hC3 + k[7:0], rec[135 - 8 * k -: 8]);
		for (int k = 0; k < 16; k++) rd_chk(8'hD4 + k[7:0], key[127 - 8 * k -: 8]);
		rd_chk(8'hE4, 8'hA9);
		rd_chk(8'hE5, 8'hD5);
	endtask
	task automatic t_events;
		u_host.wr(8'h93, 8'h01);
		ev = 32'h8000_0100;
		tick;
		ev = '0;
		tick;
		check("irq", irq, 1'b0);
		rd_chk(8'hFA, 8'h80);
		rd_chk(8'hFA, 8'h00);
		rd_chk(8'hFC, 8'h01);
		ev = 32'h0000_0001;
		tick;
		ev = '0;
		tick;
		check("irq", irq, 1'b1);
		rd_chk(8'hFD, 8'h01);
		tick;
		check("irq", irq, 1'b0);
		// an event landing on the read edge has to survive the clear
		fork
			rd_chk(8'hFA, 8'h00);
			begin
				tick;
				ev = 32'h8000_0000;
				tick;
				ev = '0;
			end
		join
		rd_chk(8'hFA, 8'h80);
	endtask
	task automatic conclude;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk);
		#1;
		rst_b = 1'b1;
		tick;
		t_reset;
		t_config;
		t_status;
		t_latched;
		t_events;
		conclude;
	end
	// traffic needs about 150 cycles; the 4000-cycle limit is over 25 times that and means a hang
	initial begin
		#200000;
		num_errors++;
		conclude;
	end
endmodule
